// *** verification/ocl_event_src.sv ***
// Purpose: Event source in place of the reference timing controller
// Assumes: The bench asks for one event at a time
// Notes:   Code 0 slip, 1 align, 2 prep, 3 start, 4 stop
`timescale 1ns/1ps
module ocl_event_src
(
   // Clock
   input  wire logic       clock_i,
   // Request
   input  wire logic       go_i,
   input  wire logic [2:0] code_i,
   // Broadcast events
   output logic [4:0]      evt_o
);
   // Every event is a one-cycle pulse launched just after an edge
   always_ff @(posedge clock_i)
   begin
      evt_o <= go_i ? (5'h01 << code_i) : 5'h00;
   end
endmodule // ocl_event_src

// *** verification/ocl_leaf_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the leaf controller
// Assumes: Events come one at a time from the event source
// Notes:   Gate and phase-reset cycles are counted in fixed windows
`timescale 1ns/1ps
module ocl_leaf_ctrl_tb_top;
   import ocl_pkg::*;
   logic        clock_i, arst_n_i, go, pwr, prst, gate, bufe, fz, flt, done, cerr;
   logic        chan_en = 1'b1, slip_acc = 1'b0, align_acc = 1'b0;
   logic        follow = 1'b0, rep_en = 1'b0;
   logic        pair_en = 1'b1, sleep = 1'b0;
   logic [1:0]  launch = OCL_LAUNCH_ASYNC, idle = OCL_IDLE_FLOAT;
   logic [2:0]  code = 3'h0;
   logic [4:0]  evt;
   logic [11:0] rep_cnt = 12'h007, div = 12'h040;
   logic [15:0] gates, rsts;
   int          err_total = 0, num_checks = 0;

   ocl_event_src src_u (.clock_i(clock_i), .go_i(go), .code_i(code), .evt_o(evt));
   ocl_leaf_ctrl dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .chan_en_i(chan_en),
      .pair_en_i(pair_en), .sleep_i(sleep), .slip_accept_i(slip_acc),
      .align_accept_i(align_acc), .launch_mode_i(launch), .buf_follow_i(follow),
      .idle_level_i(idle), .repeat_en_i(rep_en), .repeat_count_i(rep_cnt),
      .divide_ratio_i(div), .slip_req_i(evt[0]), .align_evt_i(evt[1]),
      .pulse_prep_i(evt[2]), .pulse_start_i(evt[3]), .pulse_stop_i(evt[4]),
      .div_power_o(pwr), .div_phase_reset_o(prst), .clk_gate_o(gate),
      .buf_enable_o(bufe), .force_zero_o(fz), .idle_float_o(flt),
      .phase_done_o(done), .cfg_error_o(cerr));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic ev(input logic [2:0] c);
      @(posedge clock_i);
      go <= 1'b1;
      code <= c;
      @(posedge clock_i);
      go <= 1'b0;
   endtask

   task automatic watch(input int n);
      gates = '0;
      rsts = '0;
      repeat (n)
      begin
         @(negedge clock_i);
         gates += 16'(gate === 1'b1);
         rsts += 16'(prst === 1'b1);
      end
   endtask

   task automatic t_slip();
      @(posedge clock_i);
      slip_acc <= 1'b1;
      ev(3'h0);
      watch(12);
      chk(gates, 16'h0001);
      chk(16'(done), 16'h0001);
      @(posedge clock_i);
      slip_acc <= 1'b0;
      ev(3'h0);
      watch(12);
      chk(gates, 16'h0000);
      $display("test slip done");
   endtask

   task automatic t_repeat();
      @(posedge clock_i);
      slip_acc <= 1'b1;
      rep_en <= 1'b1;
      rep_cnt <= 12'h005;
      ev(3'h0);
      watch(16);
      chk(gates, 16'h0005);
      $display("test repeat done");
   endtask

   task automatic t_align();
      @(posedge clock_i);
      align_acc <= 1'b1;
      rep_cnt <= 12'h003;
      ev(3'h1);
      watch(16);
      chk(rsts, 16'h0001);
      chk(gates, 16'h0003);
      @(posedge clock_i);
      rep_en <= 1'b0;
      @(posedge clock_i);
      align_acc <= 1'b0;
      @(posedge clock_i);
      align_acc <= 1'b1;
      @(posedge clock_i);
      align_acc <= 1'b0;
      watch(6);
      chk(rsts + gates, 16'h0000);
      chk(16'(pwr), 16'h0001);
      ev(3'h1);
      watch(8);
      chk(rsts, 16'h0000);
      $display("test align done");
   endtask

   task automatic t_off(input logic ce, input logic pe, input logic sl);
      @(posedge clock_i);
      chan_en <= ce;
      pair_en <= pe;
      sleep <= sl;
      align_acc <= 1'b1;
      ev(3'h0);
      ev(3'h1);
      watch(12);
      chk(rsts + gates, 16'h0000);
      chk(16'(pwr), 16'h0000);
      chk(16'(bufe), 16'(ce));
      @(posedge clock_i);
      chan_en <= 1'b1;
      pair_en <= 1'b1;
      sleep <= 1'b0;
      align_acc <= 1'b0;
      $display("test disable done");
   endtask

   task automatic t_dyn(input logic f, input logic [1:0] il);
      @(posedge clock_i);
      launch <= OCL_LAUNCH_DYNAMIC;
      div <= 12'h040;
      follow <= f;
      idle <= il;
      watch(4);
      chk(16'(bufe), 16'(!f));
      chk(16'(cerr), 16'h0000);
      ev(3'h2);
      watch(4);
      chk(16'(pwr), 16'h0001);
      chk(16'(bufe), 16'h0001);
      chk(16'(fz), 16'(il == OCL_IDLE_ZERO));
      chk(16'(flt), 16'(il == OCL_IDLE_FLOAT));
      ev(3'h3);
      watch(4);
      chk(rsts, 16'h0001);
      chk(16'(fz), 16'h0000);
      ev(3'h4);
      watch(4);
      chk(16'(pwr), 16'h0000);
      chk(16'(bufe), 16'(!f));
      @(posedge clock_i);
      div <= 12'h01F;
      watch(3);
      chk(16'(cerr), 16'h0001);
      @(posedge clock_i);
      launch <= OCL_LAUNCH_ASYNC;
      $display("test dynamic done");
   endtask

   task automatic final_report();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   initial
   begin
      arst_n_i = 1'b0;
      go = 1'b0;
      repeat (5) @(posedge clock_i);
      arst_n_i <= 1'b1;
      t_slip();
      t_repeat();
      t_align();
      t_off(1'b0, 1'b1, 1'b0);
      t_off(1'b1, 1'b0, 1'b0);
      t_off(1'b1, 1'b1, 1'b1);
      t_dyn(1'b1, OCL_IDLE_ZERO);
      t_dyn(1'b0, OCL_IDLE_FLOAT);
      final_report();
   end

   // Tests need a few thousand ns; this cuts a hang short
   initial
   begin
      #100000;
      err_total++;
      final_report();
   end
endmodule // ocl_leaf_ctrl_tb_top

// *** verilog/ocl_leaf_ctrl.sv ***
// Purpose: Per-channel leaf controller: slip, align, pulse launch, mute
// Assumes: Broadcast events are one-cycle pulses synchronous to clock_i
// Notes:   Phase reset and power-up are outputs toward the divider
//
// Operation
// - Slip-accept set: act on slip requests
// - Repeat enable: slip after align or start
// - Align-accept set: reset divider phase on align
// - Align-accept toggle never disturbs divider state
// - Launch 00: free start, align rephases only
// - Launch 11: power up, rephase, power down
// - Follow off: buffer tracks channel enable
// - Follow on, launch 11: buffer powered from prep until stop
// - Idle 10 and enabled: force zero when idle
// - Idle 00: outputs float to common mode
// - Idle level seen only with buffer enabled
// - Repeat enable decides whether count applies
// - Repeat on: each slip repeats count times
// - Flag done when phase operations settle
// - Channel enable 0 disables the channel
`timescale 1ns/1ps
module ocl_leaf_ctrl
   import ocl_pkg::*;
#(
   parameter int STEP_W = OCL_STEP_W,
   parameter int DIV_W  = OCL_DIV_W
)
(
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              arst_n_i,
   // Configuration
   input  wire logic              chan_en_i,
   input  wire logic              pair_en_i,
   input  wire logic              sleep_i,
   input  wire logic              slip_accept_i,
   input  wire logic              align_accept_i,
   input  wire logic [1:0]        launch_mode_i,
   input  wire logic              buf_follow_i,
   input  wire logic [1:0]        idle_level_i,
   input  wire logic              repeat_en_i,
   input  wire logic [STEP_W-1:0] repeat_count_i,
   input  wire logic [DIV_W-1:0]  divide_ratio_i,
   // Broadcast events
   input  wire logic              slip_req_i,
   input  wire logic              align_evt_i,
   input  wire logic              pulse_prep_i,
   input  wire logic              pulse_start_i,
   input  wire logic              pulse_stop_i,
   // Divider and buffer controls
   output logic                   div_power_o,
   output logic                   div_phase_reset_o,
   output logic                   clk_gate_o,
   output logic                   buf_enable_o,
   output logic                   force_zero_o,
   output logic                   idle_float_o,
   // Status
   output logic                   phase_done_o,
   output logic                   cfg_error_o
);
   typedef enum logic [1:0] {OCL_IDLE, OCL_ARMED, OCL_CHAIN} ocl_pulse_e;

   ocl_pulse_e        pstate_q;
   logic              active;
   logic              dyn_mode;
   logic              align_hit;
   logic              chain_start;
   logic              auto_slip_q;
   logic              slip_start;
   logic [STEP_W-1:0] slip_steps;
   logic              slip_gate;
   logic              slip_busy;
   logic [1:0]        settle_q;
   logic              pulsing;
   logic [STEP_W-1:0] run_q;
   logic [STEP_W-1:0] want_q;

   initial
   begin
      if (STEP_W != OCL_STEP_W || DIV_W != OCL_DIV_W)
         $error("step and divide widths must stay at 12");
   end

   assign active      = (chan_en_i == OCL_CHAN_ON) && pair_en_i && !sleep_i;
   assign dyn_mode    = (launch_mode_i == OCL_LAUNCH_DYNAMIC);
   // Accept only gates event sensitivity; divider state is not touched
   assign align_hit   = active && align_accept_i && align_evt_i;
   assign chain_start = active && dyn_mode && pulse_start_i && pstate_q == OCL_ARMED;
   assign pulsing     = (pstate_q == OCL_CHAIN);

   // Pulse chain sequencing in dynamic launch mode
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         pstate_q <= OCL_IDLE;
      else if (!active || !dyn_mode)
         pstate_q <= OCL_IDLE;
      else
      begin
         case (pstate_q)
            OCL_IDLE:  if (pulse_prep_i) pstate_q <= OCL_ARMED;
            OCL_ARMED: if (pulse_start_i) pstate_q <= OCL_CHAIN;
            OCL_CHAIN: if (pulse_stop_i) pstate_q <= OCL_IDLE;
            default:   pstate_q <= OCL_IDLE;
         endcase
      end
   end

   // Divider power and phase reset
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         div_power_o       <= 1'b0;
         div_phase_reset_o <= 1'b0;
      end
      else
      begin
         div_power_o       <= active && (!dyn_mode || pstate_q != OCL_IDLE);
         div_phase_reset_o <= align_hit || chain_start;
      end
   end

   // Automatic slip after an alignment or a chain start
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         auto_slip_q <= 1'b0;
      else
         auto_slip_q <= (repeat_en_i == OCL_REPEAT_ON) && (align_hit || chain_start);
   end

   assign slip_start = active && ((slip_accept_i && slip_req_i) || auto_slip_q);
   assign slip_steps = (repeat_en_i == OCL_REPEAT_ON) ? repeat_count_i
                                                      : STEP_W'(OCL_SLIP_CYCLES);

   ocl_slip_counter #(
      .STEP_W (STEP_W)
   ) u_slip (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .start_i  (slip_start),
      .steps_i  (slip_steps),
      .gate_o   (slip_gate),
      .busy_o   (slip_busy)
   );

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         clk_gate_o <= 1'b0;
      else
         clk_gate_o <= slip_gate;
   end

   // Output buffer enable and idle level
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         buf_enable_o <= 1'b0;
         force_zero_o <= 1'b0;
         idle_float_o <= 1'b0;
      end
      else
      begin
         if (dyn_mode && buf_follow_i == OCL_BUF_FOLLOW_ON)
            buf_enable_o <= active && pstate_q != OCL_IDLE;
         else
            buf_enable_o <= chan_en_i == OCL_CHAN_ON;
         // Idle level only matters while the buffer is on
         force_zero_o <= buf_enable_o && chan_en_i && !pulsing
                         && idle_level_i == OCL_IDLE_ZERO;
         idle_float_o <= buf_enable_o && !pulsing
                         && idle_level_i == OCL_IDLE_FLOAT;
      end
   end

   // Phase settled once no slip or rephase has run for a short while
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         settle_q     <= '0;
         phase_done_o <= 1'b0;
      end
      else if (slip_busy || slip_start || auto_slip_q || div_phase_reset_o)
      begin
         settle_q     <= '0;
         phase_done_o <= 1'b0;
      end
      else if (settle_q != 2'(OCL_SETTLE_CYCLES))
         settle_q <= settle_q + 2'h1;
      else
         phase_done_o <= 1'b1;
   end

   // Flags host misuse of settings the channel cannot serve
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         cfg_error_o <= 1'b0;
      else
         cfg_error_o <= (dyn_mode && divide_ratio_i <= DIV_W'(OCL_MIN_DYN_DIV))
                        || (repeat_en_i && repeat_count_i == '0);
   end

   // Check helpers: length of each gate run and the step count it must match
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         run_q  <= '0;
         want_q <= '0;
      end
      else
      begin
         run_q <= clk_gate_o ? run_q + STEP_W'(1) : '0;
         // Captured only when the counter really takes the start
         if (slip_start && !slip_busy && slip_steps != '0)
            want_q <= slip_steps;
      end
   end

   // Building blocks for the multi-step checks
   sequence s_align_seen;
      align_accept_i && align_evt_i && active;
   endsequence

   sequence s_slip_taken;
      slip_start && !slip_busy;
   endsequence

   sequence s_prep_seen;
      active && dyn_mode && pulse_prep_i && pstate_q == OCL_IDLE;
   endsequence

   sequence s_chain_stop;
      active && dyn_mode && pulse_stop_i && pstate_q == OCL_CHAIN;
   endsequence

   sequence s_quiet;
      !slip_busy && !slip_start && !auto_slip_q && !div_phase_reset_o;
   endsequence

   // Alignment and slip acceptance
   AST_ALIGN_RESETS: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      s_align_seen |=> div_phase_reset_o)
      else $error("accepted align did not reset phase");
   AST_ALIGN_IGNORED: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (!align_accept_i && !dyn_mode) |=> !div_phase_reset_o)
      else $error("phase reset without align accept");
   AST_SLIP_IGNORED: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (!slip_busy && slip_req_i && !slip_accept_i && !auto_slip_q) |=> ##1 !clk_gate_o)
      else $error("slip acted on while not accepted");
   // A coinciding request or a busy counter would swallow the automatic slip
   AST_AUTO_SLIP: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (s_align_seen and (repeat_en_i == OCL_REPEAT_ON && !slip_busy && !slip_start))
      ##1 (active && slip_steps != '0) |=> ##1 clk_gate_o)
      else $error("no repeat slip after alignment");
   AST_SINGLE_SLIP: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (s_slip_taken and (repeat_en_i != OCL_REPEAT_ON)) |=> ##1 clk_gate_o ##1 !clk_gate_o)
      else $error("single slip did not pause exactly one cycle");
   // A gate run must last exactly the steps captured at its start
   AST_STEP_COUNT: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      $fell(clk_gate_o) |-> run_q == $past(want_q))
      else $error("slip step count not honoured");
   // Buffer and divider power
   AST_BUF_TRACKS: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (!dyn_mode) |=> buf_enable_o == $past(chan_en_i))
      else $error("buffer enable does not track channel enable");
   AST_BUF_FOLLOWS: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (dyn_mode && buf_follow_i && pstate_q == OCL_IDLE) |=> !buf_enable_o)
      else $error("buffer on outside pulse events");
   AST_DYN_POWER: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (active && dyn_mode && pstate_q == OCL_IDLE) |=> !div_power_o)
      else $error("divider powered outside pulse chain");
   AST_PREP_POWER: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      s_prep_seen ##1 (active && dyn_mode) |=> div_power_o)
      else $error("divider not powered ahead of pulse chain");
   AST_CHAIN_RESET: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (active && dyn_mode && pulse_start_i && pstate_q == OCL_ARMED) |=> div_phase_reset_o)
      else $error("chain start did not rephase");
   AST_CHAIN_STOP: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      s_chain_stop ##1 dyn_mode |=> !div_power_o)
      else $error("divider still powered after chain end");
   // Idle level outputs
   AST_ZERO_NEEDS_BUF: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      force_zero_o |-> $past(buf_enable_o))
      else $error("idle level shown with buffer off");
   AST_FLOAT_NEEDS_BUF: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      idle_float_o |-> $past(buf_enable_o))
      else $error("float level shown with buffer off");
   AST_ZERO_SET: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (buf_enable_o && chan_en_i && !pulsing && idle_level_i == OCL_IDLE_ZERO) |=> force_zero_o)
      else $error("idle output not forced to zero");
   // Enable and completion status
   AST_DISABLED: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (!chan_en_i) |=> !div_power_o && !div_phase_reset_o)
      else $error("disabled channel still active");
   AST_DONE_CLEARS: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      slip_busy |=> !phase_done_o)
      else $error("done flagged while slipping");
   AST_DONE_SETS: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      s_quiet [*3] |=> phase_done_o)
      else $error("done not flagged after phase settled");
endmodule // ocl_leaf_ctrl

// *** verilog/ocl_pkg.sv ***
// Purpose: Shared constants for the output channel leaf controller
// Assumes: One 100 MHz clock stands in for the distribution clock
// Notes:   Launch and idle encodings are the programmed field values
package ocl_pkg;
   localparam logic [1:0] OCL_LAUNCH_ASYNC   = 2'h0;
   localparam logic [1:0] OCL_LAUNCH_DYNAMIC = 2'h3;
   localparam logic [1:0] OCL_IDLE_FLOAT     = 2'h0;
   localparam logic [1:0] OCL_IDLE_ZERO      = 2'h2;
   localparam int         OCL_STEP_W         = 12;
   localparam int         OCL_DIV_W          = 12;
   localparam int         OCL_MIN_DYN_DIV    = 31;
   localparam logic       OCL_REPEAT_ON      = 1'b1;
   localparam logic       OCL_BUF_FOLLOW_ON  = 1'b1;
   localparam logic       OCL_CHAN_ON        = 1'b1;
   // Clock cycles a single slip holds the gate closed
   localparam int         OCL_SLIP_CYCLES    = 1;
   // Quiet cycles counted before the settle check; done sets after three quiet cycles
   localparam int         OCL_SETTLE_CYCLES  = 2;
endpackage

// *** verilog/ocl_slip_counter.sv ***
// Purpose: Counts out the slip steps of one slip operation
// Assumes: Start is ignored while busy
// Notes:   Each step closes the clock gate for one cycle
`timescale 1ns/1ps
module ocl_slip_counter
   import ocl_pkg::*;
#(
   parameter int STEP_W = OCL_STEP_W
)
(
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              arst_n_i,
   // Control
   input  wire logic              start_i,
   input  wire logic [STEP_W-1:0] steps_i,
   // Status
   output logic                   gate_o,
   output logic                   busy_o
);
   logic [STEP_W-1:0] left_q;

   initial
   begin
      if (STEP_W < 1)
         $error("STEP_W must be at least 1");
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         left_q <= '0;
         gate_o <= 1'b0;
         busy_o <= 1'b0;
      end
      else if (!busy_o)
      begin
         if (start_i && steps_i != '0)
         begin
            left_q <= steps_i - STEP_W'(1);
            gate_o <= 1'b1;
            busy_o <= 1'b1;
         end
         else
            gate_o <= 1'b0;
      end
      else if (left_q != '0)
      begin
         left_q <= left_q - STEP_W'(1);
         gate_o <= 1'b1;
      end
      else
      begin
         gate_o <= 1'b0;
         busy_o <= 1'b0;
      end
   end

   AST_ONE_GATE_PER_SINGLE: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (!busy_o && start_i && steps_i == STEP_W'(1)) |=> gate_o ##1 !gate_o)
      else $error("single slip did not gate exactly one cycle");
endmodule // ocl_slip_counter
